// [hw/dmpr_access.sv]
// Top of the pattern-location access block
`timescale 1ns/10ps
module dmpr_access
	import dmpr_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              cmdMrs,      // Mode register set
	input  wire logic              cmdRead,     // Read command
	input  wire logic              cmdWrite,    // Write command
	input  wire logic [1:0]        cmdMrSel,    // Target mode register
	input  wire logic [1:0]        bankAddr,
	input  wire logic [1:0]        bankGroup,
	input  wire logic [17:0]       addr,
	input  wire logic [1:0]        burstMode,   // Burst-length field
	input  wire logic [LAT_W-1:0]  casLat,
	input  wire logic [LAT_W-1:0]  addLat,
	input  wire logic [LAT_W-1:0]  parLat,
	input  wire logic              isX16,
	output logic                   patternMode,  // Redirect active
	output logic                   arrayReady,   // Array commands allowed
	output logic [DQ_W-1:0]        dqOut,
	output logic                   dqOe_b
);
	logic [LOC_W-1:0] loc_ff [NUM_LOC];   // Pattern locations
	logic             mode_ff;            // Redirect enable
	logic [1:0]       page_ff;            // Page select
	logic [1:0]       fmt_ff;             // Readout format
	logic [4:0]       mod_ff;             // Update delay count
	logic             ready_ff;
	logic [QUE_DEPTH-1:0] qv_ff;           // Read launch delay line
	logic [3:0]       qinfo_ff [QUE_DEPTH]; // Chop, upper, location
	logic [LOC_W*NUM_LOC-1:0] locFlat;
	dmpr_rd_if rd ();
	// Mode register three write
	wire mr3Wr = cmdMrs && (cmdMrSel == 2'h3);
	wire mRead  = mode_ff && cmdRead;
	wire mWrite = mode_ff && cmdWrite && (page_ff == 2'h0);
	wire chop = (burstMode == 2'h2) ||
		((burstMode == 2'h1) && !addr[ADDR_CHOP_BIT]);
	wire [LAT_W+1:0] rl = (LAT_W+2)'(addLat) + (LAT_W+2)'(casLat)
		+ (LAT_W+2)'(parLat);
	wire [5:0] rlIdx = (rl > 8'(QUE_DEPTH-1)) ? 6'h3F :
		(rl == 8'h0 ? 6'h0 : 6'(rl - 8'h1));
	// Mode register and locations
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_ff <= 1'b0;
			page_ff <= 2'h0;
			fmt_ff  <= FMT_SERIAL;
		end else if (mr3Wr) begin
			mode_ff <= addr[MR3_EN_BIT];
			page_ff <= addr[MR3_PAGE_LO +: 2];
			fmt_ff  <= addr[MR3_FMT_LO +: 2];
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			loc_ff[0] <= LOC_RST0;
			loc_ff[1] <= LOC_RST1;
			loc_ff[2] <= LOC_RST2;
			loc_ff[3] <= LOC_RST3;
		end else if (mWrite) begin
			// bank picks, low byte stored
			// Byte kept as sent, so bit b is beat b
			// Reset values follow the same bit order
			loc_ff[bankAddr] <= addr[LOC_W-1:0];
		end
	end
	// Bit b of a location is beat b, flattened per location
	genvar i;
	generate
		for (i = 0; i < NUM_LOC; i++) begin : gFlat
			for (genvar b = 0; b < LOC_W; b++) begin : gBit
				assign locFlat[i*LOC_W + b] = loc_ff[i][b];
			end
		end
	endgenerate
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mod_ff   <= 5'h0;
			ready_ff <= 1'b1;
		end else if (mr3Wr) begin
			mod_ff   <= T_MOD_CNT;
			ready_ff <= 1'b0;
		end else if (mod_ff != 5'h0) begin
			mod_ff   <= mod_ff - 5'h1;
			ready_ff <= (mod_ff == 5'h1) && !mode_ff;
		end
	end
	// read launch delay line
	// A read drops a token into slot RL-1, tokens walk towards
	// slot zero one clock at a time, and slot zero starts the
	// shifter. The shifter adds two register stages, so the
	// first beat shows RL+1 clocks after the read edge.
	// Latencies past the line depth clamp to the last slot.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			qv_ff <= '0;
		end else begin
			// Shift towards slot zero, then drop new token
			qv_ff <= {1'b0, qv_ff[QUE_DEPTH-1:1]}
				| (mRead ? (QUE_DEPTH)'(1) << rlIdx : '0);
		end
	end
	// Side data walks beside its token
	// Left unreset: only used where a token stands
	always_ff @(posedge clk) begin
		for (int k = 0; k < QUE_DEPTH-1; k++) begin
			qinfo_ff[k] <= qinfo_ff[k+1];
		end
		qinfo_ff[QUE_DEPTH-1] <= 4'h0;
		if (mRead) begin
			qinfo_ff[rlIdx] <= {chop, addr[ADDR_ORD_BIT], bankAddr};
		end
	end
	// Token in slot zero launches the burst
	assign rd.start = qv_ff[0];
	wire [3:0] topInfo = qinfo_ff[0];
	assign rd.chop  = topInfo[3];
	assign rd.upper = topInfo[2];
	assign rd.loc   = topInfo[1:0];
	dmpr_shift uShift (
		.clk    (clk),
		.rst_b  (rst_b),
		.req    (rd),
		.locs   (locFlat),
		.fmt    (fmt_ff),
		.isX16  (isX16),
		.dqOut  (dqOut),
		.dqOe_b (dqOe_b)
	);
	// Status outputs
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			patternMode <= 1'b0;
			arrayReady  <= 1'b1;
		end else begin
			patternMode <= mode_ff;
			arrayReady  <= ready_ff;
		end
	end
endmodule // dmpr_access

// [hw/dmpr_pkg.sv]
// Package with constants for the pattern-location access block
package dmpr_pkg;
	localparam int NUM_LOC      = 4;              // Pattern locations
	localparam int LOC_W        = 8;              // Bits per location
	localparam int BURST_LEN    = 8;              // Beats per full burst
	localparam int CHOP_LEN     = 4;              // Beats driven in chop
	localparam int DQ_W         = 16;             // Widest data bus
	localparam int LAT_W        = 6;              // Latency count width
	localparam int QUE_DEPTH    = 64;             // Read delay line depth
	// Mode register 3 field positions
	localparam int MR3_EN_BIT   = 2;              // Pattern mode enable
	localparam int MR3_PAGE_LO  = 0;              // Page select low bit
	localparam int MR3_FMT_LO   = 11;             // Readout format low bit
	// Readout format codes
	localparam logic [1:0] FMT_SERIAL   = 2'h0;
	localparam logic [1:0] FMT_PARALLEL = 2'h1;
	localparam logic [1:0] FMT_STAGGER  = 2'h2;
	// Address fields for chop select and burst order
	localparam int ADDR_CHOP_BIT = 12;
	localparam int ADDR_ORD_BIT  = 2;
	// Reset contents of pattern locations
	localparam logic [7:0] LOC_RST0 = 8'h55;
	localparam logic [7:0] LOC_RST1 = 8'h33;
	localparam logic [7:0] LOC_RST2 = 8'h0F;
	localparam logic [7:0] LOC_RST3 = 8'h00;
	// Mode-register update delay in clocks
	localparam int T_MOD_CK      = 24;
	localparam logic [4:0] T_MOD_CNT = 5'h18;
endpackage

// [hw/dmpr_rd_if.sv]
// Interface carrying one read request into the output shifter
`timescale 1ns/10ps
interface dmpr_rd_if;
	logic        start;   // Burst begins this cycle
	logic        chop;    // Four-beat chop burst
	logic        upper;   // Start at beat four
	logic [1:0]  loc;     // Selected location
	modport src (output start, output chop, output upper, output loc);
	modport dst (input start, input chop, input upper, input loc);
endinterface

// [hw/dmpr_shift.sv]
// Output shifter that forms the readout beats
`timescale 1ns/10ps
module dmpr_shift
	import dmpr_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rst_b,
	dmpr_rd_if.dst                   req,
	input  wire logic [LOC_W*NUM_LOC-1:0] locs,
	input  wire logic [1:0]          fmt,
	input  wire logic                isX16,
	output logic      [DQ_W-1:0]     dqOut,
	output logic                     dqOe_b
);
	logic [2:0]  beat_ff;            // Beat index in burst
	logic [3:0]  left_ff;            // Beats still to send
	logic [1:0]  loc_ff;             // Latched location
	logic [DQ_W-1:0] nxt_dq;        // Beat data
	logic [3:0]  nxt_left;
	logic [2:0]  nxt_beat;
	wire  [7:0]  loc0 = locs[LOC_W-1:0];
	// Beat bit from any location
	function automatic logic bitOf(input logic [1:0] l, input logic [2:0] b);
		bitOf = locs[l*LOC_W + b];
	endfunction
	// Per-lane data, four lanes repeated over the bus in stagger, eight in parallel
	genvar g;
	generate
		for (g = 0; g < DQ_W; g++) begin : gLane
			wire [1:0] sl = loc_ff + 2'(g % NUM_LOC);
			assign nxt_dq[g] = (!isX16 && g >= LOC_W) ? 1'b0 :
				(fmt == FMT_STAGGER)  ? bitOf(sl, beat_ff) :
				(fmt == FMT_PARALLEL) ? loc0[g % LOC_W] :
				bitOf(loc_ff, beat_ff);
		end
	endgenerate
	assign nxt_left = req.start ? (req.chop ? 4'(CHOP_LEN) : 4'(BURST_LEN))
		: (left_ff != 4'h0 ? left_ff - 4'h1 : 4'h0);
	assign nxt_beat = req.start ? {req.upper, 2'h0} : beat_ff + 3'h1;
	// Burst counters
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			left_ff <= 4'h0;
			beat_ff <= 3'h0;
			loc_ff  <= 2'h0;
		end else begin
			left_ff <= nxt_left;
			beat_ff <= nxt_beat;
			if (req.start) begin
				loc_ff <= req.loc;
			end
		end
	end
	// Data and enable registered
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dqOut  <= '0;
			dqOe_b <= 1'b1;
		end else begin
			dqOut  <= (left_ff != 4'h0) ? nxt_dq : '0;
			dqOe_b <= (left_ff == 4'h0);
		end
	end
endmodule // dmpr_shift

// [tb/dmpr_checker.sv]
// Assertions on the pattern access ports
`timescale 1ns/10ps
module dmpr_checker
	import dmpr_pkg::*;
(
	input wire logic            clk,
	input wire logic            rst_b,
	input wire logic            cmdMrs,
	input wire logic [1:0]      cmdMrSel,
	input wire logic [17:0]     addr,
	input wire logic            isX16,
	input wire logic            patternMode,
	input wire logic            arrayReady,
	input wire logic [DQ_W-1:0] dqOut,
	input wire logic            dqOe_b
);
	// Slack on the update delay
	localparam int MOD_MAX = T_MOD_CK + 4;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Set of the pattern mode register
	sequence s_mr3;
		cmdMrs && cmdMrSel == 2'h3;
	endsequence
	// Exit from an active pattern mode
	sequence s_exit;
		s_mr3 ##0 (!addr[MR3_EN_BIT] && patternMode);
	endsequence
	chk_mode_on: assert property (
		s_mr3 ##0 addr[MR3_EN_BIT] |=> ##1 patternMode)
		else $error("mode not entered");
	chk_mode_off: assert property (
		s_exit |=> ##1 !patternMode)
		else $error("mode not left");
	chk_mode_hold: assert property (
		!cmdMrs && !$past(cmdMrs) |=> $stable(patternMode))
		else $error("mode moved alone");
	chk_ready_gap: assert property (
		s_exit |=> !arrayReady [*8])
		else $error("array ready early");
	chk_ready_back: assert property (
		s_exit |-> ##[2:MOD_MAX] arrayReady)
		else $error("array ready late");
	chk_ready_hold: assert property (
		arrayReady && !patternMode && !cmdMrs && !$past(cmdMrs)
		|=> arrayReady)
		else $error("array ready lost");
	chk_burst_min: assert property (
		$fell(dqOe_b) |-> !dqOe_b [*4])
		else $error("burst too short");
	chk_x16_copy: assert property (
		!dqOe_b && isX16 |-> dqOut[15:8] == dqOut[7:0])
		else $error("upper byte differs");
endmodule // dmpr_checker

// [tb/dmpr_ctl.sv]
// Controller model issuing pattern-mode commands
`timescale 1ns/10ps
module dmpr_ctl
	import dmpr_pkg::*;
(
	input  wire logic   clk,
	output logic        cmdMrs,
	output logic        cmdRead,
	output logic        cmdWrite,
	output logic [1:0]  cmdMrSel,
	output logic [1:0]  bankAddr,
	output logic [1:0]  bankGroup,
	output logic [17:0] addr
);
	initial {cmdMrs, cmdRead, cmdWrite, cmdMrSel} = '0;
	initial {bankAddr, bankGroup, addr} = '0;
	// One pulse, then the bus shows junk
	task automatic cmd(input int k, input logic [1:0] b,
		input logic [17:0] a);
		@(negedge clk);
		{cmdMrs, cmdRead, cmdWrite} = 3'(4 >> k);
		cmdMrSel = k == 0 ? 2'h3 : 2'($urandom);
		{bankAddr, bankGroup, addr} = {b, 2'($urandom), a};
		@(negedge clk);
		{cmdMrs, cmdRead, cmdWrite} = 3'h0;
		{bankAddr, addr} = ~{bankAddr, addr};
	endtask
	task automatic mrs(input logic [17:0] a);
		cmd(0, 2'h0, a);
		repeat (T_MOD_CK) @(negedge clk);
	endtask
	task automatic rd(input logic [1:0] b, input logic [17:0] r,
		input logic [1:0] bm);
		cmd(1, b, r & 18'h3FFF8 | (bm == 2'h1 ? 18'h01000 : 18'h0));
	endtask
	task automatic wr(input logic [1:0] b, input logic [17:0] a);
		cmd(2, b, a);
		repeat (8) @(negedge clk);
	endtask
endmodule // dmpr_ctl

// [tb/tb.sv]
// Self-checking bench for the pattern access block
`timescale 1ns/10ps
module tb;
	import dmpr_pkg::*;
	logic clk, rst_b, cmdMrs, cmdRead, cmdWrite, isX16;
	logic patternMode, arrayReady, dqOe_b;
	logic [1:0] cmdMrSel, bankAddr, bankGroup, burstMode;
	logic [17:0] addr;
	logic [LAT_W-1:0] casLat, addLat, parLat;
	logic [DQ_W-1:0] dqOut;
	int err_total, comparisons, fmt, n, d, w;
	int mem[4];
	dmpr_access i_dut(.clk(clk), .rst_b(rst_b), .cmdMrs(cmdMrs),
		.cmdRead(cmdRead), .cmdWrite(cmdWrite), .cmdMrSel(cmdMrSel),
		.bankAddr(bankAddr), .bankGroup(bankGroup), .addr(addr),
		.burstMode(burstMode), .casLat(casLat), .addLat(addLat),
		.parLat(parLat), .isX16(isX16), .patternMode(patternMode),
		.arrayReady(arrayReady), .dqOut(dqOut), .dqOe_b(dqOe_b));
	dmpr_ctl i_ctl(.clk(clk), .cmdMrs(cmdMrs), .cmdRead(cmdRead),
		.cmdWrite(cmdWrite), .cmdMrSel(cmdMrSel), .bankAddr(bankAddr),
		.bankGroup(bankGroup), .addr(addr));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task tally_and_finish;
		if (err_total == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic cmp(input logic [DQ_W:0] g, input logic [DQ_W:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %0t %h %h", $time, g, e);
		end
	endtask
	// Expected beat; x8 parts leave the upper byte unchecked
	function automatic logic [DQ_W:0] beat(int s, int i);
		logic [DQ_W-1:0] v;
		for (int j = 0; j < DQ_W; j++)
			v[j] = fmt == 1 ? mem[0][j % 8] : mem[fmt == 2 ? (s + j) % 4 : s][i];
		return {1'b0, v & (isX16 ? 16'hFFFF : 16'h00FF)};
	endfunction
	// Read, time the first beat, then walk the burst
	task automatic rdchk(input int s, input logic [1:0] bm);
		i_ctl.rd(2'(s), 18'($urandom), bm);
		for (n = 0; n < 90 && dqOe_b !== 1'b0; n++) @(negedge clk);
		cmp(17'(n), 17'(addLat + casLat + parLat + 1));
		for (int i = 0; i < BURST_LEN; i++) begin
			if (bm == 2'h2 && i >= CHOP_LEN)
				cmp({dqOe_b, 16'h0}, 17'h10000);
			else
				cmp({dqOe_b, dqOut & (isX16 ? 16'hFFFF : 16'h00FF)}, beat(s, i));
			@(negedge clk);
		end
	endtask
	initial begin
		void'($urandom(99963));
		{rst_b, isX16, burstMode, addLat, parLat} = '0;
		casLat = 6'hB;
		mem = '{LOC_RST0, LOC_RST1, LOC_RST2, LOC_RST3};
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		for (int t = 0; t < 12; t++) begin
			fmt = t % 3;
			isX16 = t[1];
			burstMode = 2'((t / 3) % 3);
			casLat = 6'(9 + $urandom % 12);
			addLat = 6'($urandom % 3);
			parLat = 6'($urandom % 5);
			d = $urandom;
			w = $urandom % 4;
			i_ctl.mrs(18'(fmt << 11 | 4 | (t == 5)));
			i_ctl.wr(2'(w), 18'(d));
			if (t != 5)
				mem[w] = d & 255;
			i_ctl.mrs(18'(fmt << 11 | 4));
			rdchk(fmt == 1 ? 0 : t % 4, burstMode);
		end
		i_ctl.mrs(18'h0);
		// Ready flag is registered once more past the update delay
		@(negedge clk);
		cmp(17'(patternMode), 17'h0);
		cmp(17'(arrayReady), 17'h1);
		i_ctl.wr(2'h1, 18'($urandom));
		i_ctl.mrs(18'h1004);
		fmt = 2;
		rdchk(1, 2'h0);
		tally_and_finish();
	end
	// Hang guard, far beyond the expected run
	initial begin
		#5000000;
		err_total++;
		tally_and_finish();
	end
endmodule // tb
bind dmpr_access dmpr_checker i_chk(.clk(clk), .rst_b(rst_b),
	.cmdMrs(cmdMrs), .cmdMrSel(cmdMrSel), .addr(addr), .isX16(isX16),
	.patternMode(patternMode), .arrayReady(arrayReady),
	.dqOut(dqOut), .dqOe_b(dqOe_b));
